/* verilog/apr_pkg.sv */
// Purpose: Shared constants and carriers for the converter read-port host.
// Assumes: 10 MHz clk_in, converter pins synchronous to clk_in.
// Notes:   Cycle counts are rounded up to whole clocks.
// Function
// RULE_01: Converter result port is eight bits wide.
// RULE_02: Converter latches channel address on read strobe falling edge.
// RULE_03: Convert-start falling edge puts hold and starts conversion.
// RULE_04: Finished conversion loads output register, end strobe pulses low.
// RULE_05: End strobe low at most 110 ns, then self-releases.
// RULE_06: Read strobe rising edge releases end strobe at once.
// RULE_07: Converter drives result while chip-select and read are low.
// RULE_08: Chip-select may stay low; read strobe alone then controls data.
// RULE_09: Logic host may loop end strobe onto chip-select and read.
// RULE_10: Host treats falling end strobe as conversion-done event.
// RULE_11: Host drives channel address from three low address bits.
// RULE_12: Chip-select decode ignores low three address bits.
// RULE_13: Single-channel variant needs no channel address inputs.
// RULE_14: Stand-alone: convert-start alone starts, looped end strobe reads.
// RULE_15: Convert-start low at end-strobe rise selects power-down.
// RULE_16: Convert-start rising edge powers converter up again.
// RULE_17: High-speed mode: next start at least 30 ns after read ends.
// RULE_18: Conversion completes within 420 ns of convert-start fall.
// RULE_19: Converter data port floats while chip-select or read high.
// RULE_20: One end pulse per conversion; result held until next.
package apr_pkg;
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned CLK_NS       = 1_000_000_000 / CLK_HZ;
    localparam int unsigned CONV_MAX_NS  = 420;
    localparam int unsigned REACQ_MIN_NS = 30;
    localparam int unsigned START_LOW_NS = 100;
    localparam int unsigned EOC_LOW_MAX_NS = 110;
    localparam int unsigned CONV_TO_CYC  =
        (CONV_MAX_NS + EOC_LOW_MAX_NS + CLK_NS - 1) / CLK_NS + 2;
    localparam int unsigned REACQ_CYC    =
        (REACQ_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned START_LOW_CYC =
        (START_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned CHAN_W       = 3;
    localparam int unsigned CNT_W        = 8;

    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic [DATA_W-1:0] data;
        logic              timeout;
    } apr_sample_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_START = 3'h1,
        ST_WAIT  = 3'h3,
        ST_READ  = 3'h2,
        ST_REL   = 3'h6,
        ST_GAP   = 3'h7
    } apr_state_e;
endpackage

/* verilog/apr_buf2.sv */
// Purpose: Two-entry valid/ready buffer for captured samples.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Ready in drops only when both entries are held.
`timescale 1ns/1ns
module apr_buf2 #(
    parameter int unsigned W = 12
) (
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              rd;
        logic              wr;
        logic [1:0]        cnt;
    } apr_buf_state_s;

    apr_buf_state_s s_r;
    apr_buf_state_s s_nxt;
    logic           push;
    logic           pop;

    assign in_ready_out  = (s_r.cnt != 2'h2);
    assign out_valid_out = (s_r.cnt != 2'h0);
    assign out_data_out  = s_r.mem[s_r.rd];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wr] = in_data_in;
            s_nxt.wr = ~s_r.wr;
        end
        if (pop) begin
            s_nxt.rd = ~s_r.rd;
        end
        case ({push, pop})
            2'b10:   s_nxt.cnt = s_r.cnt + 2'h1;
            2'b01:   s_nxt.cnt = s_r.cnt - 2'h1;
            default: s_nxt.cnt = s_r.cnt;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

/* verilog/apr_host.sv */
// Purpose: Host controller that runs conversions and reads the converter.
// Assumes: Converter pins synchronous to clk_in; pins sampled directly.
// Notes:   Results leave through a two-entry buffer; a full buffer stalls
//          the next conversion start so no word is lost.
`timescale 1ns/1ns
module apr_host #(
    parameter int unsigned DATA_W  = apr_pkg::DATA_W,
    parameter int unsigned CHAN_W  = apr_pkg::CHAN_W,
    parameter logic        LOOPBACK = 1'b0
) (
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    // Command side
    input  wire logic              start_in,
    input  wire logic [CHAN_W-1:0] chan_in,
    input  wire logic              power_down_in,
    output logic                   busy_out,
    // Sample stream
    output logic                   smp_valid_out,
    input  wire logic              smp_ready_in,
    output apr_pkg::apr_sample_s   smp_out,
    output logic                   done_pulse_out,
    // Converter pins
    output logic                   convert_start_n_out,
    output logic                   cs_n_out,
    output logic                   rd_n_out,
    output logic [CHAN_W-1:0]      chan_addr_out,
    input  wire logic              eoc_n_in,
    input  wire logic [DATA_W-1:0] data_in
);
    import apr_pkg::*;

    typedef struct packed {
        apr_state_e        st;
        logic              cvst_n;
        logic              cs_n;
        logic              rd_n;
        logic [CHAN_W-1:0] addr;
        logic              pwr_dn;
        logic [CNT_W-1:0]  cnt;
        logic              eoc_d;
        logic [DATA_W-1:0] data;
        logic              tmo;
        logic              wvalid;
        logic              done;
    } apr_host_state_s;

    apr_host_state_s s_r;
    apr_host_state_s s_nxt;
    logic            buf_ready;
    logic            eoc_fall;
    apr_sample_s     wsample;

    assign eoc_fall = s_r.eoc_d && !eoc_n_in; // RULE_10
    assign wsample  = '{chan: s_r.addr, data: s_r.data, timeout: s_r.tmo};

    always_comb begin
        s_nxt = s_r;
        s_nxt.eoc_d = eoc_n_in;
        s_nxt.done = 1'b0;
        if (buf_ready) begin
            s_nxt.wvalid = 1'b0;
        end
        unique case (s_r.st)
            ST_IDLE: begin
                if (start_in && !s_r.wvalid && buf_ready) begin
                    // Address bits only steer the channel, never select
                    s_nxt.addr = chan_in; // RULE_11 RULE_12
                    s_nxt.pwr_dn = power_down_in;
                    s_nxt.tmo = 1'b0;
                    s_nxt.cvst_n = 1'b0; // RULE_03
                    s_nxt.cnt = '0;
                    s_nxt.st = ST_START;
                end
            end
            ST_START: begin
                s_nxt.cnt = s_r.cnt + CNT_W'(1);
                // Fast mode raises convert-start early; power-down keeps it
                // low across the end-strobe rise
                if (!s_r.pwr_dn &&
                    s_nxt.cnt >= CNT_W'(START_LOW_CYC)) begin
                    s_nxt.cvst_n = 1'b1; // RULE_15
                end
                if (eoc_fall) begin // RULE_04
                    s_nxt.st = ST_READ;
                end else if (s_r.cnt >= CNT_W'(CONV_TO_CYC)) begin
                    s_nxt.tmo = 1'b1; // RULE_18
                    s_nxt.st = ST_READ;
                end
                if (LOOPBACK && s_nxt.st == ST_READ) begin
                    // Looped strobe drives the bus only while it is low
                    if (eoc_fall) begin
                        s_nxt.data = data_in; // RULE_09
                    end
                    s_nxt.st = ST_WAIT; // RULE_14
                end
                if (!LOOPBACK && s_nxt.st == ST_READ) begin
                    s_nxt.cs_n = 1'b0; // RULE_07
                    s_nxt.rd_n = 1'b0; // RULE_02
                end
            end
            ST_WAIT: begin
                // Result taken at the end-strobe fall; on timeout take it here, else wait for the looped strobe to rise
                if (eoc_n_in || s_r.tmo) begin // RULE_05
                    if (s_r.tmo) begin
                        s_nxt.data = data_in;
                    end
                    s_nxt.st = ST_REL;
                end
            end
            ST_READ: begin
                s_nxt.data = data_in; // RULE_01 RULE_08
                s_nxt.cs_n = 1'b1;
                s_nxt.rd_n = 1'b1; // RULE_06 RULE_19
                s_nxt.st = ST_REL;
            end
            ST_REL: begin
                s_nxt.wvalid = 1'b1; // RULE_20
                s_nxt.done = 1'b1;
                s_nxt.cnt = '0;
                s_nxt.st = ST_GAP;
            end
            ST_GAP: begin
                // Power-down: rising convert-start wakes the converter
                s_nxt.cvst_n = 1'b1; // RULE_16
                s_nxt.cnt = s_r.cnt + CNT_W'(1);
                if (s_nxt.cnt >= CNT_W'(REACQ_CYC)) begin // RULE_17
                    s_nxt.st = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s_r <= '{st: ST_IDLE, cvst_n: 1'b1, cs_n: 1'b1, rd_n: 1'b1,
                     eoc_d: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    apr_buf2 #(
        .W ($bits(apr_sample_s))
    ) u_buf (
        .clk_in        (clk_in),
        .srst_in       (srst_in),
        .in_valid_in   (s_r.wvalid),
        .in_ready_out  (buf_ready),
        .in_data_in    (wsample),
        .out_valid_out (smp_valid_out),
        .out_ready_in  (smp_ready_in),
        .out_data_out  (smp_out)
    );

    // Single-channel converters leave chan_addr_out unconnected
    assign chan_addr_out       = s_r.addr; // RULE_13
    assign convert_start_n_out = s_r.cvst_n;
    assign cs_n_out            = s_r.cs_n;
    assign rd_n_out            = s_r.rd_n;
    assign busy_out            = (s_r.st != ST_IDLE);
    assign done_pulse_out      = s_r.done;
endmodule

/* test/apr_chk.sv */
// Purpose: Port assertions for the converter host.
// Assumes: Read-strobe checks apply only with LOOPBACK at 0; one clock.
// Notes:   Bound onto apr_host below.
`timescale 1ns/1ns
module apr_chk #(
    parameter logic LOOPBACK = 1'b0
) (
    input wire logic                 clk_in,
    input wire logic                 srst_in,
    input wire logic                 power_down_in,
    input wire logic                 busy_out,
    input wire logic                 smp_valid_out,
    input wire logic                 smp_ready_in,
    input wire apr_pkg::apr_sample_s smp_out,
    input wire logic                 done_pulse_out,
    input wire logic                 convert_start_n_out,
    input wire logic                 cs_n_out,
    input wire logic                 rd_n_out,
    input wire logic [2:0]           chan_addr_out,
    input wire logic                 eoc_n_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    rst_idle_a:
        assert property ($fell(srst_in) |-> cs_n_out && rd_n_out
            && convert_start_n_out && !busy_out)
        else $error("not idle");
    strobe_pair_a:
        assert property (cs_n_out == rd_n_out)
        else $error("strobes split");
    eoc_read_a:
        assert property (!LOOPBACK && $fell(eoc_n_in) && busy_out
            |-> ##[1:2] !rd_n_out)
        else $error("no read");
    eoc_done_a:
        assert property ($fell(eoc_n_in) && busy_out |-> ##3 done_pulse_out)
        else $error("late done");
    chan_hold_a:
        assert property (!rd_n_out |-> $stable(chan_addr_out))
        else $error("chan moved");
    done_after_a:
        assert property ($rose(rd_n_out) |-> ##[0:1] done_pulse_out)
        else $error("no done");
    done_once_a:
        assert property (done_pulse_out |=> !done_pulse_out)
        else $error("long done");
    conv_bound_a:
        assert property ($fell(convert_start_n_out) |-> ##[1:60]
            done_pulse_out)
        else $error("no result");
    start_len_a:
        assert property ($fell(convert_start_n_out) |=>
            convert_start_n_out == !power_down_in)
        else $error("start len");
    reacq_gap_a:
        assert property ($rose(rd_n_out) && !power_down_in |=>
            convert_start_n_out)
        else $error("early start");
    cover property (smp_valid_out && smp_out.timeout);
    cover property (LOOPBACK && done_pulse_out);
    cover property (smp_valid_out && !smp_ready_in);
    cover property (power_down_in && $fell(convert_start_n_out));
endmodule
bind apr_host apr_chk #(.LOOPBACK(LOOPBACK)) apr_chk_i (.clk_in, .srst_in,
    .power_down_in,
    .busy_out, .smp_valid_out, .smp_ready_in, .smp_out, .done_pulse_out,
    .convert_start_n_out, .cs_n_out, .rd_n_out, .chan_addr_out, .eoc_n_in);

/* test/apr_dev_model.sv */
// Purpose: Behavioural converter facing the host pins.
// Assumes: Pins move on clk_in edges; end strobe one cycle.
// Notes:   Undriven data reads back inverted.
`timescale 1ns/1ns
module apr_dev_model (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       convert_start_n_in,
    input  wire logic       cs_n_in,
    input  wire logic       rd_n_in,
    input  wire logic [2:0] chan_in,
    input  wire logic       hang_in,
    input  wire logic [1:0] dly_in,
    output logic            eoc_n_out,
    output logic [7:0]      data_out
);
    logic       cst_r, rd_r, busy_r, off_r;
    logic [1:0] cnt_r;
    logic [2:0] chan_r;
    logic [7:0] res_r, num_r;
    assign data_out = (!cs_n_in && !rd_n_in)
        ? res_r : ~res_r;
    always_ff @(posedge clk_in) begin
        cst_r <= convert_start_n_in;
        rd_r <= rd_n_in;
        eoc_n_out <= 1'b1;
        if (rd_r && !rd_n_in) chan_r <= chan_in;
        if (srst_in) begin
            busy_r <= 1'b0;
            off_r <= 1'b0;
            res_r <= 8'h00;
            num_r <= 8'h00;
        end else begin
            if (cst_r && !convert_start_n_in) begin
                busy_r <= !hang_in && !off_r;
                cnt_r <= dly_in;
            end else if (busy_r && cnt_r != 2'h0) cnt_r <= cnt_r - 2'h1;
            else if (busy_r) begin
                busy_r <= 1'b0;
                res_r <= num_r * 8'h1D + 8'h03;
                num_r <= num_r + 8'h01;
                eoc_n_out <= 1'b0;
            end
            if (!eoc_n_out) off_r <= !convert_start_n_in;
            else if (!cst_r && convert_start_n_in) off_r <= 1'b0;
        end
    end
endmodule

/* test/apr_host_tb.sv */
// Purpose: Self-checking bench for the converter host.
// Assumes: Converter model on the pins.
// Notes:   Stream is stalled at random.
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module apr_host_tb;
    import apr_pkg::*;
    logic clk_in = 0, srst_in = 1, start_in = 0, power_down_in = 0;
    logic smp_ready_in = 0, busy_out, smp_valid_out, done_pulse_out;
    logic convert_start_n_out, cs_n_out, rd_n_out, eoc_n_in;
    logic hang = 0, stall = 0;
    logic [2:0] chan_in = 0, chan_addr_out, cur_ch = 0;
    logic [1:0] dly = 0;
    logic [7:0] data_in, last = 0, nexp = 0;
    logic [31:0] seed = 32'h57D140CC, r;
    apr_sample_s smp_out, ex, got;
    apr_sample_s exp_q[$];
    int errors = 0, total_checks = 0;
    logic lb_eoc_n, lb_cvst_n, lb_valid;
    logic [7:0] lb_data, lb_n = 0;
    apr_sample_s lb_smp;
    apr_host apr_host_i (.clk_in, .srst_in, .start_in, .chan_in,
        .power_down_in, .busy_out, .smp_valid_out, .smp_ready_in, .smp_out,
        .done_pulse_out, .convert_start_n_out, .cs_n_out, .rd_n_out,
        .chan_addr_out, .eoc_n_in, .data_in);
    apr_dev_model apr_dev_model_i (.clk_in, .srst_in,
        .convert_start_n_in(convert_start_n_out), .cs_n_in(cs_n_out),
        .rd_n_in(rd_n_out), .chan_in(chan_addr_out), .hang_in(hang),
        .dly_in(dly), .eoc_n_out(eoc_n_in), .data_out(data_in));
    // Second host with the end strobe looped onto the read pins
    apr_host #(.LOOPBACK(1'b1)) apr_host_lb_i (.clk_in, .srst_in, .start_in,
        .chan_in, .power_down_in, .busy_out(), .smp_valid_out(lb_valid),
        .smp_ready_in(1'b1), .smp_out(lb_smp), .done_pulse_out(),
        .convert_start_n_out(lb_cvst_n), .cs_n_out(), .rd_n_out(),
        .chan_addr_out(), .eoc_n_in(lb_eoc_n), .data_in(lb_data));
    apr_dev_model apr_dev_model_lb_i (.clk_in, .srst_in,
        .convert_start_n_in(lb_cvst_n), .cs_n_in(lb_eoc_n),
        .rd_n_in(lb_eoc_n), .chan_in(3'h0),
        .hang_in(hang), .dly_in(dly), .eoc_n_out(lb_eoc_n),
        .data_out(lb_data));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] resf(input logic [7:0] n);
        return n * 8'h1D + 8'h03;
    endfunction
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic conv(input logic [2:0] ch, input logic pw, hg,
                        input logic [1:0] d);
        int k;
        k = 0;
        start_in <= 1'b1;
        chan_in <= ch;
        power_down_in <= pw;
        hang <= hg;
        dly <= d;
        cur_ch = ch;
        do @(negedge clk_in); while (busy_out !== 1'b1 && ++k < 300);
        @(posedge clk_in);
        start_in <= 1'b0;
        ex = '{ch, hg ? last : resf(nexp), hg};
        exp_q.push_back(ex);
        if (!hg) last = resf(nexp++);
        do @(negedge clk_in); while (busy_out !== 1'b0 && ++k < 300);
        if (k >= 300) errors++;
        @(posedge clk_in);
    endtask
    initial forever #50 clk_in = ~clk_in;
    initial begin
        #2_000_000;
        errors++;
        give_verdict();
    end
    always @(posedge clk_in) smp_ready_in <= !stall && (^rnd());
    always @(negedge clk_in) begin
        if (rd_n_out === 1'b0) `CHK("chan", cur_ch, chan_addr_out)
        if (smp_valid_out === 1'b1 && smp_ready_in === 1'b1) begin
            got = exp_q.pop_front();
            `CHK("sample", got, smp_out)
        end
        if (lb_valid === 1'b1 && lb_smp.timeout === 1'b0) begin
            `CHK("loop data", resf(lb_n), lb_smp.data)
            lb_n++;
        end
    end
    initial begin
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        stall = 1'b1;
        fork begin repeat (60) @(posedge clk_in); stall = 1'b0; end join_none
        for (int i = 0; i < 4; i++) conv(3'(i), 1'b0, 1'b0, 2'h3);
        $display("test stall done");
        conv(3'h5, 1'b0, 1'b1, 2'h0);
        conv(3'h6, 1'b1, 1'b0, 2'h0);
        conv(3'h7, 1'b1, 1'b0, 2'h3);
        $display("test corner done");
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            conv(r[2:0], r[3], &r[6:4], r[8:7]);
        end
        $display("test random done");
        repeat (20) @(posedge clk_in);
        `CHK("left", 0, exp_q.size())
        `CHK("loop runs", 1'b1, lb_n != 8'h00)
        give_verdict();
    end
endmodule
